// [hpp_pkg.sv]
// constants and types for the dual channel host parallel port
package hpp_pkg;
  // ----------------------------------------------------------------
  // cpu side addresses
  // ----------------------------------------------------------------
  localparam logic [15:0] SERIAL_TIMER_CONTROL_ADDR = 16'hffc3;
  localparam logic [15:0] SYSTEM_CONTROL_ADDR       = 16'hffc4;
  localparam logic [15:0] PORT_CONTROL_ADDR         = 16'hfff0;
  localparam logic [15:0] INPUT_DATA_ADDR  [2]      = '{16'hfff4, 16'hfffc};
  localparam logic [15:0] OUTPUT_DATA_ADDR [2]      = '{16'hfff5, 16'hfffd};
  localparam logic [15:0] STATUS_ADDR      [2]      = '{16'hfff6, 16'hfffe};
  localparam logic [11:0] SLAVE_RANGE_TOP           = 12'hfff;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] SERIAL_TIMER_CONTROL_RST = 8'h00;
  localparam logic [7:0] SYSTEM_CONTROL_RST       = 8'h09;
  localparam logic [7:0] PORT_CONTROL_RST         = 8'hf8;
  localparam logic [7:0] STATUS_RST               = 8'h00;
  localparam logic [7:0] DATA_RST                 = 8'h00;
  localparam logic       GATE_RST                 = 1'b1;

  // ----------------------------------------------------------------
  // field positions and masks
  // ----------------------------------------------------------------
  localparam int         PORT_ENABLE_BIT    = 1;
  localparam int         SYSCTL_RO_BIT      = 3;
  localparam int         FAST_GATE_EN_BIT   = 0;
  localparam int         INPUT_IRQ_EN_BIT [2] = '{1, 2};
  localparam logic [7:0] SYSCTL_WR_MASK     = 8'hf7;
  localparam logic [7:0] PORT_CONTROL_MASK  = 8'h07;
  localparam logic [7:0] STATUS_CPU_WR_MASK = 8'hf4;
  localparam logic [7:0] GATE_CMD           = 8'hd1;
  localparam int         GATE_DATA_BIT      = 1;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [3:0] user_bits_hi;
    logic       cmd_flag;
    logic       user_bits_lo;
    logic       input_full_flag;
    logic       output_full_flag;
  } chan_status_t;

  typedef struct packed {
    logic chan_one_select_n;
    logic chan_two_select_n;
    logic cmd_data_select;
    logic host_read_strobe_n;
    logic host_write_strobe_n;
  } host_ctrl_t;
endpackage

// [host_channel.sv]
// one channel: input data, output data and status registers
`timescale 1ns/1ps
`default_nettype none
module host_channel (
  // clock and reset
  input  wire logic                 sys_clk,
  input  wire logic                 rst,
  // on-chip cpu strobes
  input  wire logic                 cpu_rd_input,
  input  wire logic                 cpu_wr_output,
  input  wire logic                 cpu_wr_status,
  input  wire logic [7:0]           cpu_wdata,
  // host side events
  input  wire logic                 host_wr,
  input  wire logic                 host_rd_done,
  input  wire logic                 host_cmd,
  input  wire logic [7:0]           host_wdata,
  // register contents
  output logic [7:0]                input_data,
  output logic [7:0]                output_data,
  output hpp_pkg::chan_status_t     status
);
  logic [7:0]            idr_ff;
  logic [7:0]            nxt_idr;
  logic [7:0]            odr_ff;
  logic [7:0]            nxt_odr;
  hpp_pkg::chan_status_t str_ff;
  hpp_pkg::chan_status_t nxt_str;

  // ----------------------------------------------------------------
  // next state: sets are applied last so they win over clears
  // ----------------------------------------------------------------
  always_comb begin
    nxt_idr = idr_ff;
    nxt_odr = odr_ff;
    nxt_str = str_ff;
    if (cpu_wr_status) begin
      nxt_str = hpp_pkg::chan_status_t'((str_ff & ~hpp_pkg::STATUS_CPU_WR_MASK) |
                (cpu_wdata & hpp_pkg::STATUS_CPU_WR_MASK));
    end
    if (host_rd_done) begin
      nxt_str.output_full_flag = 1'b0;
    end
    if (cpu_wr_output) begin
      nxt_odr                  = cpu_wdata;
      nxt_str.output_full_flag = 1'b1;
    end
    if (cpu_rd_input) begin
      nxt_str.input_full_flag = 1'b0;
    end
    if (host_wr) begin
      nxt_idr                 = host_wdata;
      nxt_str.cmd_flag        = host_cmd;
      nxt_str.input_full_flag = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      idr_ff <= hpp_pkg::DATA_RST;
      odr_ff <= hpp_pkg::DATA_RST;
      str_ff <= hpp_pkg::STATUS_RST;
    end else begin
      idr_ff <= nxt_idr;
      odr_ff <= nxt_odr;
      str_ff <= nxt_str;
    end
  end

  assign input_data  = idr_ff;
  assign output_data = odr_ff;
  assign status      = str_ff;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  input_load_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    host_wr |=> (status.input_full_flag && input_data == $past(host_wdata)
                 && status.cmd_flag == $past(host_cmd)))
    else $error("host write did not load input register");

  output_drain_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    (host_rd_done && !cpu_wr_output) |=> !status.output_full_flag)
    else $error("host read did not clear output full");

  status_ro_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    (cpu_wr_status && !host_wr && !host_rd_done && !cpu_wr_output && !cpu_rd_input)
    |=> ($stable(status[3]) && $stable(status[1:0])
         && status[7:4] == $past(cpu_wdata[7:4])))
    else $error("status write touched read only bits");
endmodule
`default_nettype wire

// [dual_channel_host_parallel_port.sv]
// two channel host parallel port with on-chip cpu register access
`timescale 1ns/1ps
`default_nettype none
module dual_channel_host_parallel_port (
  // clock and reset
  input  wire logic                sys_clk,
  input  wire logic                rst,
  // on-chip cpu register port
  input  wire logic [15:0]         cpu_addr,
  input  wire logic                cpu_rd_en,
  input  wire logic                cpu_wr_en,
  input  wire logic [7:0]          cpu_wdata,
  output logic [7:0]               cpu_rdata,
  output logic [1:0]               cpu_input_irq,
  output logic [7:0]               serial_timer_control,
  // host pins
  input  wire hpp_pkg::host_ctrl_t host_ctrl,
  input  wire logic [7:0]          host_bus_in,
  output logic [7:0]               host_bus_out,
  output logic                     host_bus_oe,
  // host requests and address line gate
  output logic                     host_irq_a,
  output logic                     host_irq_b,
  output logic                     host_irq_c,
  output logic                     addr_line_gate_out
);
  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [7:0]            sysctl_ff;
  logic [7:0]            nxt_sysctl;
  logic [7:0]            sertim_ff;
  logic [7:0]            nxt_sertim;
  logic [7:0]            pctl_ff;
  logic [7:0]            nxt_pctl;
  logic [7:0]            rdata_ff;
  logic [7:0]            nxt_rdata;
  logic                  gate_ff;
  logic                  nxt_gate;
  logic                  armed_ff;
  logic                  nxt_armed;
  hpp_pkg::host_ctrl_t   prev_ctrl_ff;
  logic [7:0]            prev_bus_ff;
  logic [7:0]            bus_out_ff;
  logic [7:0]            nxt_bus_out;
  logic                  port_en;
  logic                  slave_range;
  logic                  cpu_ok;
  logic                  wr_rise;
  logic                  rd_rise;
  logic [1:0]            prev_sel;
  logic [1:0]            now_sel;
  logic [1:0]            host_wr;
  logic [1:0]            host_rd_done;
  logic [1:0]            cpu_rd_input;
  logic [1:0]            cpu_wr_output;
  logic [1:0]            cpu_wr_status;
  logic [7:0]            input_data  [2];
  logic [7:0]            output_data [2];
  hpp_pkg::chan_status_t status      [2];

  // ----------------------------------------------------------------
  // enables and decode
  // ----------------------------------------------------------------
  assign port_en     = sysctl_ff[hpp_pkg::PORT_ENABLE_BIT];
  assign slave_range = (cpu_addr[15:4] == hpp_pkg::SLAVE_RANGE_TOP);
  assign cpu_ok      = !slave_range || port_en;

  // channel one: first select low, second high; channel two the reverse
  assign prev_sel = {!prev_ctrl_ff.chan_two_select_n && prev_ctrl_ff.chan_one_select_n,
                     !prev_ctrl_ff.chan_one_select_n && prev_ctrl_ff.chan_two_select_n};
  assign now_sel  = {!host_ctrl.chan_two_select_n && host_ctrl.chan_one_select_n,
                     !host_ctrl.chan_one_select_n && host_ctrl.chan_two_select_n};

  // strobe rising edges, judged against the previous sample
  assign wr_rise = port_en && !prev_ctrl_ff.host_write_strobe_n
                   && host_ctrl.host_write_strobe_n;
  assign rd_rise = port_en && !prev_ctrl_ff.host_read_strobe_n
                   && host_ctrl.host_read_strobe_n;

  // ----------------------------------------------------------------
  // channels
  // ----------------------------------------------------------------
  for (genvar i = 0; i < 2; i++) begin : g_chan
    assign host_wr[i]       = wr_rise && prev_sel[i];
    assign host_rd_done[i]  = rd_rise && prev_sel[i] && !prev_ctrl_ff.cmd_data_select;
    assign cpu_rd_input[i]  = cpu_rd_en && port_en
                              && cpu_addr == hpp_pkg::INPUT_DATA_ADDR[i];
    assign cpu_wr_output[i] = cpu_wr_en && port_en
                              && cpu_addr == hpp_pkg::OUTPUT_DATA_ADDR[i];
    assign cpu_wr_status[i] = cpu_wr_en && port_en
                              && cpu_addr == hpp_pkg::STATUS_ADDR[i];
    assign cpu_input_irq[i] = status[i].input_full_flag
                              && pctl_ff[hpp_pkg::INPUT_IRQ_EN_BIT[i]];

    host_channel u_chan (
      .sys_clk       (sys_clk),
      .rst           (rst),
      .cpu_rd_input  (cpu_rd_input[i]),
      .cpu_wr_output (cpu_wr_output[i]),
      .cpu_wr_status (cpu_wr_status[i]),
      .cpu_wdata     (cpu_wdata),
      .host_wr       (host_wr[i]),
      .host_rd_done  (host_rd_done[i]),
      .host_cmd      (prev_ctrl_ff.cmd_data_select),
      .host_wdata    (prev_bus_ff),
      .input_data    (input_data[i]),
      .output_data   (output_data[i]),
      .status        (status[i])
    );
  end

  // ----------------------------------------------------------------
  // cpu side registers and read data
  // ----------------------------------------------------------------
  always_comb begin
    nxt_sysctl = sysctl_ff;
    nxt_sertim = sertim_ff;
    nxt_pctl   = pctl_ff;
    nxt_rdata  = 8'h00;
    if (cpu_wr_en) begin
      if (cpu_addr == hpp_pkg::SYSTEM_CONTROL_ADDR) begin
        nxt_sysctl = (sysctl_ff & ~hpp_pkg::SYSCTL_WR_MASK)
                     | (cpu_wdata & hpp_pkg::SYSCTL_WR_MASK);
      end
      if (cpu_addr == hpp_pkg::SERIAL_TIMER_CONTROL_ADDR) begin
        nxt_sertim = cpu_wdata;
      end
      if (cpu_addr == hpp_pkg::PORT_CONTROL_ADDR && cpu_ok) begin
        nxt_pctl = (hpp_pkg::PORT_CONTROL_RST & ~hpp_pkg::PORT_CONTROL_MASK)
                   | (cpu_wdata & hpp_pkg::PORT_CONTROL_MASK);
      end
    end
    if (cpu_rd_en && cpu_ok) begin
      if (cpu_addr == hpp_pkg::SYSTEM_CONTROL_ADDR) begin
        nxt_rdata = sysctl_ff;
      end
      if (cpu_addr == hpp_pkg::SERIAL_TIMER_CONTROL_ADDR) begin
        nxt_rdata = sertim_ff;
      end
      if (cpu_addr == hpp_pkg::PORT_CONTROL_ADDR) begin
        nxt_rdata = pctl_ff;
      end
      for (int i = 0; i < 2; i++) begin
        if (cpu_addr == hpp_pkg::INPUT_DATA_ADDR[i]) begin
          nxt_rdata = input_data[i];
        end
        if (cpu_addr == hpp_pkg::OUTPUT_DATA_ADDR[i]) begin
          nxt_rdata = output_data[i];
        end
        if (cpu_addr == hpp_pkg::STATUS_ADDR[i]) begin
          nxt_rdata = status[i];
        end
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sysctl_ff <= hpp_pkg::SYSTEM_CONTROL_RST;
      sertim_ff <= hpp_pkg::SERIAL_TIMER_CONTROL_RST;
      pctl_ff   <= hpp_pkg::PORT_CONTROL_RST;
      rdata_ff  <= 8'h00;
    end else begin
      sysctl_ff <= nxt_sysctl;
      sertim_ff <= nxt_sertim;
      pctl_ff   <= nxt_pctl;
      rdata_ff  <= nxt_rdata;
    end
  end

  assign cpu_rdata            = rdata_ff;
  assign serial_timer_control = sertim_ff;

  // ----------------------------------------------------------------
  // host side: pin samples, read data, fast address gate
  // ----------------------------------------------------------------
  always_comb begin
    nxt_bus_out = 8'h00;
    nxt_gate    = gate_ff;
    nxt_armed   = armed_ff;
    for (int i = 0; i < 2; i++) begin
      if (now_sel[i]) begin
        nxt_bus_out = host_ctrl.cmd_data_select ? status[i] : output_data[i];
      end
    end
    if (host_wr[0] && pctl_ff[hpp_pkg::FAST_GATE_EN_BIT]) begin
      if (prev_ctrl_ff.cmd_data_select) begin
        nxt_armed = (prev_bus_ff == hpp_pkg::GATE_CMD);
      end else begin
        if (armed_ff) begin
          nxt_gate = prev_bus_ff[hpp_pkg::GATE_DATA_BIT];
        end
        nxt_armed = 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      prev_ctrl_ff <= '1;
      prev_bus_ff  <= 8'h00;
      bus_out_ff   <= 8'h00;
      gate_ff      <= hpp_pkg::GATE_RST;
      armed_ff     <= 1'b0;
    end else begin
      prev_ctrl_ff <= host_ctrl;
      prev_bus_ff  <= host_bus_in;
      bus_out_ff   <= nxt_bus_out;
      gate_ff      <= nxt_gate;
      armed_ff     <= nxt_armed;
    end
  end

  assign host_bus_out = bus_out_ff;
  assign host_bus_oe  = port_en && !host_ctrl.host_read_strobe_n
                        && (now_sel != 2'b00);
  assign host_irq_a         = port_en && status[0].output_full_flag;
  assign host_irq_b         = port_en && status[1].output_full_flag;
  assign host_irq_c         = port_en && status[1].user_bits_lo;
  assign addr_line_gate_out = gate_ff;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  idle_float_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    !port_en |-> (!host_bus_oe && !host_irq_a && !host_irq_b && !host_irq_c))
    else $error("disabled port is active on host pins");

  single_drive_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    host_bus_oe |-> (!host_ctrl.host_read_strobe_n
                     && (host_ctrl.chan_one_select_n ^ host_ctrl.chan_two_select_n)))
    else $error("host bus driven outside a single select read");

  status_read_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    (port_en && now_sel[0] && host_ctrl.cmd_data_select)
    |=> host_bus_out == $past(status[0]))
    else $error("status not returned on command read");

  data_read_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    (port_en && now_sel[1] && !host_ctrl.cmd_data_select)
    |=> host_bus_out == $past(output_data[1]))
    else $error("output data not returned on data read");

  gated_read_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    (cpu_rd_en && slave_range && !port_en) |=> cpu_rdata == 8'h00)
    else $error("slave range readable while disabled");

  sysctl_ro_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    (cpu_wr_en && cpu_addr == hpp_pkg::SYSTEM_CONTROL_ADDR)
    |=> (sysctl_ff[3] == $past(sysctl_ff[3]) && sysctl_ff[2:0] == $past(cpu_wdata[2:0])))
    else $error("system control bit 3 changed by cpu");

  irq_gate_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    (host_wr[0] && !pctl_ff[1] && !(cpu_wr_en && cpu_addr == hpp_pkg::PORT_CONTROL_ADDR))
    |=> (status[0].input_full_flag && !cpu_input_irq[0]))
    else $error("input irq raised while disabled");

  chan_decode_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    host_wr[1] |-> (!prev_ctrl_ff.chan_two_select_n && prev_ctrl_ff.chan_one_select_n
                    && !host_wr[0]))
    else $error("channel two written without its select");
endmodule
`default_nettype wire

// [host_model.sv]
// external host processor model on the eight bit parallel bus
`timescale 1ns/1ps
`default_nettype none
module host_model (
  // clock
  input  wire logic          sys_clk,
  // device drive side
  input  wire logic [7:0]    host_bus_out,
  input  wire logic          host_bus_oe,
  // host pins
  output hpp_pkg::host_ctrl_t host_ctrl,
  output logic [7:0]         host_bus_in
);
  // ----------------------------------------------------------------
  // bus level
  // ----------------------------------------------------------------
  localparam logic [4:0] IDLE = 5'h1b;
  logic [7:0] drv;
  logic       drv_en;
  logic [7:0] last;

  initial begin
    host_ctrl = IDLE;
    drv       = 8'h00;
    drv_en    = 1'b0;
    last      = 8'h00;
  end

  // released bus shows a changing pattern, never the last value
  always_comb begin
    host_bus_in = host_bus_oe ? host_bus_out : (drv_en ? drv : ~last);
  end

  always_ff @(posedge sys_clk) begin
    last <= host_bus_in;
  end

  // ----------------------------------------------------------------
  // host cycles
  // ----------------------------------------------------------------
  task automatic sel(input logic [1:0] ch, input logic cmd);
    host_ctrl.chan_one_select_n = ~ch[0];
    host_ctrl.chan_two_select_n = ~ch[1];
    host_ctrl.cmd_data_select   = cmd;
  endtask

  task automatic wr(input logic [1:0] ch, input logic cmd, input logic [7:0] data);
    @(negedge sys_clk);
    sel(ch, cmd);
    drv = data;
    drv_en = 1'b1;
    host_ctrl.host_write_strobe_n = 1'b0;
    repeat (2) @(negedge sys_clk);
    host_ctrl.host_write_strobe_n = 1'b1;
    @(negedge sys_clk);
    host_ctrl = IDLE;
    drv_en = 1'b0;
    repeat (2) @(negedge sys_clk);
  endtask

  task automatic rd(input logic [1:0] ch, input logic cmd, output logic [7:0] data,
                    output logic oe);
    @(negedge sys_clk);
    sel(ch, cmd);
    host_ctrl.host_read_strobe_n = 1'b0;
    repeat (2) @(negedge sys_clk);
    data = host_bus_in;
    oe = host_bus_oe;
    host_ctrl.host_read_strobe_n = 1'b1;
    @(negedge sys_clk);
    host_ctrl = IDLE;
    repeat (2) @(negedge sys_clk);
  endtask
endmodule
`default_nettype wire

// [tb_top.sv]
// self-checking testbench for the dual channel host parallel port
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic               sys_clk = 1'b0;
  logic               rst = 1'b1;
  logic [15:0]        cpu_addr = 16'h0000;
  logic               cpu_rd_en = 1'b0;
  logic               cpu_wr_en = 1'b0;
  logic [7:0]         cpu_wdata = 8'h00;
  logic [7:0]         cpu_rdata;
  logic [1:0]         cpu_input_irq;
  logic [7:0]         serial_timer_control;
  hpp_pkg::host_ctrl_t host_ctrl;
  logic [7:0]         host_bus_in;
  logic [7:0]         host_bus_out;
  logic               host_bus_oe;
  logic               host_irq_a;
  logic               host_irq_b;
  logic               host_irq_c;
  logic               addr_line_gate_out;
  int                 failures = 0;
  int                 n_compared = 0;
  logic [7:0]         hd;
  logic               hoe;

  initial begin
    forever #50 sys_clk = ~sys_clk;
  end

  dual_channel_host_parallel_port dut (
    .sys_clk(sys_clk), .rst(rst), .cpu_addr(cpu_addr), .cpu_rd_en(cpu_rd_en),
    .cpu_wr_en(cpu_wr_en), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata),
    .cpu_input_irq(cpu_input_irq), .serial_timer_control(serial_timer_control),
    .host_ctrl(host_ctrl), .host_bus_in(host_bus_in), .host_bus_out(host_bus_out),
    .host_bus_oe(host_bus_oe), .host_irq_a(host_irq_a), .host_irq_b(host_irq_b),
    .host_irq_c(host_irq_c), .addr_line_gate_out(addr_line_gate_out));

  host_model host (
    .sys_clk(sys_clk), .host_bus_out(host_bus_out), .host_bus_oe(host_bus_oe),
    .host_ctrl(host_ctrl), .host_bus_in(host_bus_in));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic final_report;
    if (failures == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cpu_wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    cpu_addr = a;
    cpu_wdata = d;
    cpu_wr_en = 1'b1;
    @(negedge sys_clk);
    cpu_wr_en = 1'b0;
  endtask

  task automatic cpu_rd(input logic [15:0] a, input logic [7:0] exp);
    @(negedge sys_clk);
    cpu_addr = a;
    cpu_rd_en = 1'b1;
    @(negedge sys_clk);
    cpu_rd_en = 1'b0;
    chk(cpu_rdata, exp);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic s_reset;
    cpu_rd(16'hffc4, 8'h09);
    cpu_rd(16'hffc3, 8'h00);
    cpu_rd(16'hfff0, 8'h00);
    chk({7'h00, addr_line_gate_out}, 8'h01);
    chk({6'h00, cpu_input_irq}, 8'h00);
  endtask

  task automatic s_disabled;
    host.wr(2'd1, 1'b0, 8'h77);
    cpu_wr(16'hfff5, 8'h11);
    host.rd(2'd1, 1'b0, hd, hoe);
    chk({7'h00, hoe}, 8'h00);
    chk({7'h00, host_irq_a}, 8'h00);
  endtask

  task automatic s_config;
    cpu_wr(16'hffc4, 8'h02);
    cpu_rd(16'hffc4, 8'h0a);
    cpu_rd(16'hfff6, 8'h00);
    cpu_wr(16'hffc3, 8'h5a);
    chk(serial_timer_control, 8'h5a);
    cpu_wr(16'hfff0, 8'h06);
    cpu_rd(16'hfff0, 8'hfe);
  endtask

  task automatic s_host_write;
    host.wr(2'd1, 1'b1, 8'ha5);
    cpu_rd(16'hfff6, 8'h0a);
    chk({6'h00, cpu_input_irq}, 8'h01);
    host.wr(2'd2, 1'b0, 8'h3c);
    cpu_rd(16'hfffe, 8'h02);
    chk({6'h00, cpu_input_irq}, 8'h03);
    cpu_rd(16'hfff4, 8'ha5);
    cpu_rd(16'hfff6, 8'h08);
    cpu_rd(16'hfffc, 8'h3c);
    chk({6'h00, cpu_input_irq}, 8'h00);
  endtask

  task automatic s_irq_mask;
    cpu_wr(16'hfff0, 8'h00);
    host.wr(2'd1, 1'b0, 8'h11);
    chk({6'h00, cpu_input_irq}, 8'h00);
    cpu_rd(16'hfff6, 8'h02);
    cpu_rd(16'hfff4, 8'h11);
  endtask

  task automatic s_host_read;
    cpu_wr(16'hfff5, 8'h55);
    chk({7'h00, host_irq_a}, 8'h01);
    host.rd(2'd1, 1'b1, hd, hoe);
    chk(hd, 8'h01);
    chk({7'h00, hoe}, 8'h01);
    host.rd(2'd1, 1'b0, hd, hoe);
    chk(hd, 8'h55);
    chk({7'h00, host_irq_a}, 8'h00);
    cpu_rd(16'hfff6, 8'h00);
    cpu_wr(16'hfffd, 8'hc3);
    chk({7'h00, host_irq_b}, 8'h01);
    host.rd(2'd2, 1'b0, hd, hoe);
    chk(hd, 8'hc3);
    chk({7'h00, host_irq_b}, 8'h00);
  endtask

  task automatic s_dual_select;
    host.rd(2'd3, 1'b0, hd, hoe);
    chk({7'h00, hoe}, 8'h00);
    host.rd(2'd0, 1'b0, hd, hoe);
    chk({7'h00, hoe}, 8'h00);
  endtask

  task automatic s_user_bits;
    cpu_wr(16'hfffe, 8'hff);
    cpu_rd(16'hfffe, 8'hf4);
    chk({7'h00, host_irq_c}, 8'h01);
    host.rd(2'd2, 1'b1, hd, hoe);
    chk(hd, 8'hf4);
    cpu_wr(16'hfffe, 8'h00);
    chk({7'h00, host_irq_c}, 8'h00);
  endtask

  task automatic s_gate;
    cpu_wr(16'hfff0, 8'h01);
    host.wr(2'd1, 1'b1, 8'hd1);
    host.wr(2'd1, 1'b0, 8'h00);
    chk({7'h00, addr_line_gate_out}, 8'h00);
    host.wr(2'd1, 1'b1, 8'hd1);
    host.wr(2'd1, 1'b0, 8'h02);
    chk({7'h00, addr_line_gate_out}, 8'h01);
    // data write with no command before it leaves the gate alone
    host.wr(2'd1, 1'b0, 8'h00);
    chk({7'h00, addr_line_gate_out}, 8'h01);
  endtask

  task automatic s_disable;
    cpu_wr(16'hffc4, 8'h00);
    cpu_rd(16'hffc4, 8'h08);
    cpu_rd(16'hfff6, 8'h00);
    host.rd(2'd1, 1'b1, hd, hoe);
    chk({7'h00, hoe}, 8'h00);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (3) @(negedge sys_clk);
    rst = 1'b0;
    s_reset();
    s_disabled();
    s_config();
    s_host_write();
    s_irq_mask();
    s_host_read();
    s_dual_select();
    s_user_bits();
    s_gate();
    s_disable();
    final_report();
  end

  initial begin
    repeat (3000) @(posedge sys_clk);
    failures++;
    $display("[ERR] %0t run did not finish in time", $time);
    final_report();
  end
endmodule
`default_nettype wire
